// ### core/can_core_id_timing_test_regs.sv
// Purpose: Release, byte-order, data bit timing, test and watchdog registers
// Assumes: APB slave on clk; CAN clock equals clk; core signals on clk
// Notes:   No wait state on any APB access
//
// Register access over APB was chosen for this implementation.
`include "can_regs_map.svh"
`default_nettype none
module can_core_id_timing_test_regs
#(
    parameter logic [3:0] VERSION_MAJOR = 4'h1, // Build release digit
    parameter logic [3:0] VERSION_MINOR = 4'h0, // Build step digit
    parameter logic [3:0] VERSION_PATCH = 4'h0, // Build sub-step digit
    parameter logic [3:0] BUILD_YEAR = 4'h0, // One BCD digit
    parameter logic [7:0] BUILD_DATE_MM = 8'h01, // Two BCD digits
    parameter logic [7:0] BUILD_DATE_DD = 8'h01 // Two BCD digits
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic canRxPin,
    output logic canTxPin,
    input wire logic coreTxNext,
    output logic coreRx,
    output logic samplePoint,
    output logic bitEnd,
    output logic txDelayCompEn,
    output logic [4:0] dataSyncJumpWidth,
    input wire logic startedIndexValid,
    input wire logic [4:0] startedTxBufferIndex,
    input wire logic preparedIndexValid,
    input wire logic [4:0] preparedTxBufferIndex,
    input wire logic scheduleTxCtrl,
    input wire logic scheduleMuxCtrl,
    output logic txCtrlPin,
    output logic muxCtrlPin,
    input wire logic ramSel,
    input wire logic ramReady,
    output logic watchdogTimeoutFlag,
    output logic loopbackActive
);
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    wdog_if w (); // Watchdog carrier
    logic [31:0] bitTiming_r; // Data bit timing register
    logic [31:0] mode_r; // Init, change-enable, test enable
    logic [1:0] txSel_r; // Transmit pin source
    logic loopback_r; // Internal loop-back
    logic forceTx_r; // Force transmit-control pin
    logic forceMux_r; // Force multiplexer-control pin
    logic [7:0] wdStart_r; // Watchdog start value
    logic rxMeta_r; // First synchroniser stage
    logic rxSync_r; // Second synchroniser stage
    logic [4:0] tqCnt_r; // Clocks within a quantum
    logic [5:0] segCnt_r; // Quanta within a bit
    logic nextBit_r; // Bit taken after sample point
    logic txBit_r; // Bit on the wire
    logic spMark_r; // Sample point marker
    logic bitEnd_r; // End of bit marker
    logic canTx_r; // Transmit pin
    logic coreRx_r; // Receive to core
    logic txCtrl_r; // Transmit-control pin
    logic muxCtrl_r; // Multiplexer-control pin
    logic timeout_r; // Timeout event
    logic [31:0] prdata_r; // Read data
    logic pready_r; // Access-phase ready
    logic pslverr_r; // Unmapped address
    logic [31:0] readMux; // Decoded read value
    logic mapped; // Address hits a word
    logic wrStrobe; // Write completes now
    logic protOpen; // Protected writes allowed
    logic testOn; // Test mode
    logic [4:0] brp; // Prescaler field
    logic [5:0] seg1Len; // Segment before sample point
    logic [5:0] bitLast; // Last quantum index
    logic tqTick; // Quantum ends
    logic running; // Bit timing active

    // ----------------------------------------
    // Decode of configuration
    // ----------------------------------------
    // Protected writes need change-enable with init
    assign protOpen = mode_r[`MODE_CCE_BIT] & mode_r[`MODE_INIT_BIT];
    assign testOn = mode_r[`MODE_TEST_BIT];
    assign brp = bitTiming_r[`DBT_BRP_LSB +: 5]; // Applied plus one
    // Segment before sample point plus one
    assign seg1Len = {1'b0, bitTiming_r[`DBT_SEG1_LSB +: 5]} + 6'h01;
    // Sync + seg1+1 + seg2+1 = seg1 + seg2 + 3 quanta
    assign bitLast = seg1Len + {2'b00, bitTiming_r[`DBT_SEG2_LSB +: 4]} + 6'h01;
    assign running = ~mode_r[`MODE_INIT_BIT];
    assign tqTick = running && (tqCnt_r == brp);
    assign wrStrobe = psel & penable & pready_r & pwrite;

    // ----------------------------------------
    // Address decode and read mux
    // ----------------------------------------
    always_comb
    begin
        readMux = 32'h00000000;
        mapped = 1'b1;
        unique case (paddr)
            `OFS_CORE_RELEASE_ID:
                // Release digits and build date
                readMux = {VERSION_MAJOR, VERSION_MINOR, VERSION_PATCH, BUILD_YEAR,
                           BUILD_DATE_MM, BUILD_DATE_DD};
            `OFS_BYTE_ORDER_CHECK:
                readMux = `BYTE_ORDER_PATTERN;
            `OFS_CUSTOMER_SPECIFIC:
                readMux = 32'h00000000; // Empty slot
            `OFS_DATA_BIT_TIMING:
                readMux = bitTiming_r;
            `OFS_TEST_CONTROL:
            begin
                // Live status and controls
                readMux[`TST_STARTED_INDEX_VALID_BIT] = startedIndexValid;
                readMux[`TST_SIDX_LSB +: 5] = startedTxBufferIndex;
                readMux[`TST_PREPARED_INDEX_VALID_BIT] = preparedIndexValid;
                readMux[`TST_PIDX_LSB +: 5] = preparedTxBufferIndex;
                readMux[`TST_RX_BIT] = rxSync_r;
                readMux[`TST_TX_LSB +: 2] = txSel_r;
                readMux[`TST_LOOPBACK_ENABLE_BIT] = loopback_r;
                readMux[`TST_CAT_BIT] = txCtrl_r; // Pin levels
                readMux[`TST_CAM_BIT] = muxCtrl_r;
                readMux[`TST_TAT_BIT] = forceTx_r;
                readMux[`TST_TAM_BIT] = forceMux_r;
            end
            `OFS_RAM_WATCHDOG:
                readMux = {16'h0000, w.liveCount, wdStart_r};
            `OFS_CORE_MODE:
                readMux = mode_r;
            default:
                mapped = 1'b0;
        endcase
    end

    // ----------------------------------------
    // APB answer: no wait state, data from flops
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            pready_r <= 1'b0;
            prdata_r <= 32'h00000000;
            pslverr_r <= 1'b0;
        end
        else if (psel && !penable && !pready_r)
        begin
            // Setup phase seen: answer in the access phase
            pready_r <= 1'b1;
            prdata_r <= pwrite ? 32'h00000000 : readMux;
            pslverr_r <= ~mapped;
        end
        else
        begin
            pready_r <= 1'b0;
            prdata_r <= 32'h00000000;
            pslverr_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // Mode register: init, change-enable, test enable
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            mode_r <= `MODE_RESET;
        else if (wrStrobe && paddr == `OFS_CORE_MODE)
        begin
            mode_r <= 32'h00000000; // Other bits stay zero
            mode_r[`MODE_INIT_BIT] <= pwdata[`MODE_INIT_BIT];
            mode_r[`MODE_CCE_BIT] <= pwdata[`MODE_CCE_BIT];
            mode_r[`MODE_TEST_BIT] <= pwdata[`MODE_TEST_BIT];
        end
    end

    // ----------------------------------------
    // Protected configuration registers
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            bitTiming_r <= `DBT_RESET;
        else if (wrStrobe && paddr == `OFS_DATA_BIT_TIMING && protOpen)
            // Only documented fields kept
            bitTiming_r <= pwdata & 32'h009F1FFF;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            wdStart_r <= `WDOG_START_RESET;
        else if (wrStrobe && paddr == `OFS_RAM_WATCHDOG && protOpen)
            wdStart_r <= pwdata[7:0];
    end

    // ----------------------------------------
    // Test controls, cleared whenever test mode is off
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_b || !testOn)
        begin
            // Leaving test mode restores reset values
            txSel_r <= 2'h0;
            loopback_r <= 1'b0;
            forceTx_r <= 1'b0;
            forceMux_r <= 1'b0;
        end
        else if (wrStrobe && paddr == `OFS_TEST_CONTROL)
        begin
            // Writes only reach here in test mode
            txSel_r <= pwdata[`TST_TX_LSB +: 2];
            loopback_r <= pwdata[`TST_LOOPBACK_ENABLE_BIT];
            forceTx_r <= pwdata[`TST_TAT_BIT];
            forceMux_r <= pwdata[`TST_TAM_BIT];
        end
    end

    // ----------------------------------------
    // Receive pin synchroniser
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            rxMeta_r <= 1'b1;
            rxSync_r <= 1'b1;
        end
        else
        begin
            rxMeta_r <= canRxPin;
            rxSync_r <= rxMeta_r;
        end
    end

    // ----------------------------------------
    // Data-phase quantum and bit counters
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_b || !running)
        begin
            tqCnt_r <= 5'h00;
            segCnt_r <= 6'h00;
        end
        else if (tqTick)
        begin
            // Quantum is prescaler plus one clocks
            tqCnt_r <= 5'h00;
            segCnt_r <= (segCnt_r == bitLast) ? 6'h00 : segCnt_r + 6'h01;
        end
        else
            tqCnt_r <= tqCnt_r + 5'h01;
    end

    // ----------------------------------------
    // Sample point, bit end and transmit bit pipeline
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            spMark_r <= 1'b0;
            bitEnd_r <= 1'b0;
            nextBit_r <= 1'b1;
            txBit_r <= 1'b1;
        end
        else
        begin
            spMark_r <= tqTick && (segCnt_r == seg1Len);
            bitEnd_r <= tqTick && (segCnt_r == bitLast);
            // Next bit is taken at the first edge after the sample point
            if (spMark_r)
                nextBit_r <= coreTxNext;
            if (bitEnd_r)
                txBit_r <= nextBit_r;
        end
    end

    // ----------------------------------------
    // Pins: transmit source, loop-back, schedule pins
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            canTx_r <= 1'b1;
            coreRx_r <= 1'b1;
            txCtrl_r <= 1'b0;
            muxCtrl_r <= 1'b0;
        end
        else
        begin
            unique case (can_regs_pkg::tx_src_t'(txSel_r))
                can_regs_pkg::TX_CORE: canTx_r <= txBit_r;
                can_regs_pkg::TX_SAMPLE: canTx_r <= spMark_r;
                can_regs_pkg::TX_DOMINANT: canTx_r <= 1'b0;
                can_regs_pkg::TX_RECESSIVE: canTx_r <= 1'b1;
            endcase
            // Loop-back feeds transmit back to the core
            coreRx_r <= loopback_r ? canTx_r : rxSync_r;
            // Test bits OR into sequencer outputs
            txCtrl_r <= scheduleTxCtrl | forceTx_r;
            muxCtrl_r <= scheduleMuxCtrl | forceMux_r;
        end
    end

    // ----------------------------------------
    // Watchdog hookup
    // ----------------------------------------
    assign w.startValue = wdStart_r;
    assign w.ramSel = ramSel;
    assign w.ramReady = ramReady;

    ram_watchdog uWdog
    (
        .clk(clk),
        .rst_b(rst_b),
        .w(w.wd)
    );

    // Timeout event re-registered for the interrupt logic
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            timeout_r <= 1'b0;
        else
            timeout_r <= w.timeout;
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign canTxPin = canTx_r;
    assign coreRx = coreRx_r;
    assign samplePoint = spMark_r;
    assign bitEnd = bitEnd_r;
    assign txDelayCompEn = bitTiming_r[`DBT_TDC_BIT];
    assign dataSyncJumpWidth = {1'b0, bitTiming_r[`DBT_SJW_LSB +: 4]} + 5'h01;
    assign txCtrlPin = txCtrl_r;
    assign muxCtrlPin = muxCtrl_r;
    assign watchdogTimeoutFlag = timeout_r;
    assign loopbackActive = loopback_r;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    sequence sWriteTiming;
        wrStrobe && paddr == `OFS_DATA_BIT_TIMING;
    endsequence
    sequence sReadOf(logic [11:0] a);
        psel && !penable && !pready_r && !pwrite && paddr == a;
    endsequence

    AST_RELEASE_WORD: assert property (@(posedge clk) disable iff (!rst_b)
        sReadOf(`OFS_CORE_RELEASE_ID) |=> prdata[31:16] ==
            {VERSION_MAJOR, VERSION_MINOR, VERSION_PATCH, BUILD_YEAR})
        else $error("release digits wrong");
    AST_BUILD_DATE: assert property (@(posedge clk) disable iff (!rst_b)
        sReadOf(`OFS_CORE_RELEASE_ID) |=> prdata[15:0] ==
            {BUILD_DATE_MM, BUILD_DATE_DD})
        else $error("build date wrong");
    AST_BYTE_ORDER: assert property (@(posedge clk) disable iff (!rst_b)
        sReadOf(`OFS_BYTE_ORDER_CHECK) |=> pready && prdata == `BYTE_ORDER_PATTERN)
        else $error("byte-order word wrong");
    AST_TIMING_LOCKED: assert property (@(posedge clk) disable iff (!rst_b)
        sWriteTiming and !protOpen |=> $stable(bitTiming_r))
        else $error("bit timing changed while locked");
    AST_TIMING_TAKEN: assert property (@(posedge clk) disable iff (!rst_b)
        sWriteTiming and protOpen |=> bitTiming_r == ($past(pwdata) & 32'h009F1FFF))
        else $error("bit timing write lost");
    AST_QUANTUM_LEN: assert property (@(posedge clk) disable iff (!rst_b)
        tqTick && running ##1 (running && $stable(brp))[*1] |->
            tqCnt_r == 5'h00)
        else $error("quantum counter not restarted");
    AST_SAMPLE_THEN_END: assert property (@(posedge clk) disable iff (!rst_b)
        spMark_r |-> !bitEnd_r && segCnt_r == seg1Len + 6'h01)
        else $error("sample point at wrong quantum");
    AST_NEXT_BIT: assert property (@(posedge clk) disable iff (!rst_b)
        spMark_r |=> nextBit_r == $past(coreTxNext))
        else $error("next bit not taken after sample point");
    AST_TEST_CLEARED: assert property (@(posedge clk) disable iff (!rst_b)
        !testOn |=> txSel_r == 2'h0 && !loopback_r && !forceTx_r && !forceMux_r)
        else $error("test controls not cleared");
    AST_TX_FORCE: assert property (@(posedge clk) disable iff (!rst_b)
        txSel_r == 2'h2 |=> !canTx_r)
        else $error("dominant force not on pin");
    AST_SCHED_OR: assert property (@(posedge clk) disable iff (!rst_b)
        forceTx_r |=> txCtrlPin && (!$past(forceMux_r) || muxCtrlPin))
        else $error("schedule pin not forced");
    AST_WD_DISABLED: assert property (@(posedge clk) disable iff (!rst_b)
        wdStart_r == 8'h00 ##1 wdStart_r == 8'h00 |-> w.liveCount == 8'h00 && !w.timeout)
        else $error("watchdog active with zero start");
endmodule
`default_nettype wire

// ### core/can_regs_map.svh
// Purpose: Offsets, field positions and reset values of the low register group
// Assumes: 32-bit APB data, one register per aligned word
// Notes:   Definitions only; included by bare name
//
// What this block does
// - Release word: major, minor, patch, year nibbles
// - Release word: BCD month and day, read-only
// - Byte-order word always reads 0x87654321
// - Bit timing writable only with change-enable and init
// - Bit time 3..49 quanta, quantum prescaler+1 clocks
// - Bit time is both segments plus three
// - Next bit data taken right after sample point
// - Bit 23 enables transmitter delay compensation
// - Prescaler 20:16 applied plus one
// - Segment and jump width fields applied plus one
// - Bit timing resets to 0x00000A33
// - Test register needs test enable; clearing resets
// - Started buffer index 20:16, valid bit 21
// - Prepared buffer index 12:8, valid bit 13
// - Bit 7 mirrors receive pin level
// - Field 6:5 selects transmit pin source
// - Bit 4 enables internal loop-back
// - Bits 3,2 read back schedule pin levels
// - Bits 1,0 OR-force schedule pins high
// - RAM access loads watchdog from start value
// - Ready reloads; reaching zero stops and flags
// - Live count in 15:8; start zero disables
// - Change-enable grants writes only with init
`ifndef CAN_REGS_MAP_SVH
`define CAN_REGS_MAP_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CORE_RELEASE_ID 12'h000
`define OFS_BYTE_ORDER_CHECK 12'h004
`define OFS_CUSTOMER_SPECIFIC 12'h008
`define OFS_DATA_BIT_TIMING 12'h00C
`define OFS_TEST_CONTROL 12'h010
`define OFS_RAM_WATCHDOG 12'h014
`define OFS_CORE_MODE 12'h018
// ----------------------------------------
// Values
// ----------------------------------------
`define BYTE_ORDER_PATTERN 32'h87654321
`define DBT_RESET 32'h00000A33
`define MODE_RESET 32'h00000001
`define WDOG_START_RESET 8'h00
// ----------------------------------------
// Field positions
// ----------------------------------------
`define DBT_TDC_BIT 23
`define DBT_BRP_LSB 16
`define DBT_SEG1_LSB 8
`define DBT_SEG2_LSB 4
`define DBT_SJW_LSB 0
`define TST_STARTED_INDEX_VALID_BIT 21
`define TST_SIDX_LSB 16
`define TST_PREPARED_INDEX_VALID_BIT 13
`define TST_PIDX_LSB 8
`define TST_RX_BIT 7
`define TST_TX_LSB 5
`define TST_LOOPBACK_ENABLE_BIT 4
`define TST_CAT_BIT 3
`define TST_CAM_BIT 2
`define TST_TAT_BIT 1
`define TST_TAM_BIT 0
`define WD_LIVE_LSB 8
`define MODE_INIT_BIT 0
`define MODE_CCE_BIT 1
`define MODE_TEST_BIT 7
`endif

// ### core/can_regs_pkg.sv
// Purpose: Types shared by the register group
// Assumes: Nothing beyond SystemVerilog
// Notes:   Constants live in the map header
`default_nettype none
package can_regs_pkg;
    // Transmit pin source select
    typedef enum logic [1:0] {TX_CORE, TX_SAMPLE, TX_DOMINANT, TX_RECESSIVE} tx_src_t;
    // Watchdog phase
    typedef enum logic [1:0] {WD_IDLE, WD_COUNT, WD_STOPPED} wd_state_t;
endpackage
`default_nettype wire

// ### core/ram_watchdog.sv
// Purpose: Message RAM watchdog down-counter on the host clock
// Assumes: RAM select and ready are on clk
// Notes:   Start value zero keeps the counter idle
`include "can_regs_map.svh"
`default_nettype none
module ram_watchdog
(
    input wire logic clk,
    input wire logic rst_b,
    wdog_if.wd w
);
    can_regs_pkg::wd_state_t state_r; // Counter phase
    logic [7:0] count_r; // Live value
    logic timeout_r; // Timeout event
    // ----------------------------------------
    // Counter
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            state_r <= can_regs_pkg::WD_IDLE;
            count_r <= `WDOG_START_RESET;
            timeout_r <= 1'b0;
        end
        else
        begin
            timeout_r <= 1'b0;
            if (w.startValue == 8'h00)
            begin
                // Disabled
                state_r <= can_regs_pkg::WD_IDLE;
                count_r <= 8'h00;
            end
            else if (w.ramReady)
            begin
                // Completion reloads and ends the watch
                state_r <= can_regs_pkg::WD_IDLE;
                count_r <= w.startValue;
            end
            else if (w.ramSel && state_r != can_regs_pkg::WD_COUNT)
            begin
                // Access starts the count
                state_r <= can_regs_pkg::WD_COUNT;
                count_r <= w.startValue;
            end
            else if (state_r == can_regs_pkg::WD_COUNT)
            begin
                count_r <= count_r - 8'h01;
                if (count_r == 8'h01)
                begin
                    // Reached zero: stop and flag
                    state_r <= can_regs_pkg::WD_STOPPED;
                    timeout_r <= 1'b1;
                end
            end
        end
    end
    assign w.liveCount = count_r;
    assign w.timeout = timeout_r;
    // Timeout only after the count walked down through one
    AST_WD_TIMEOUT_CAUSE: assert property (@(posedge clk) disable iff (!rst_b)
        w.timeout |-> $past(count_r) == 8'h01 && count_r == 8'h00)
        else $error("watchdog timeout without count reaching zero");
endmodule
`default_nettype wire

// ### core/wdog_if.sv
// Purpose: Carrier between register group and RAM watchdog
// Assumes: Single clock
// Notes:   ctl side owns configuration, wd side owns the counter
`default_nettype none
interface wdog_if;
    logic [7:0] startValue; // Configured start value
    logic ramSel; // Message RAM access
    logic ramReady; // RAM completion
    logic [7:0] liveCount; // Live counter
    logic timeout; // One-cycle timeout event
    modport ctl (output startValue, ramSel, ramReady, input liveCount, timeout);
    modport wd (input startValue, ramSel, ramReady, output liveCount, timeout);
endinterface
`default_nettype wire

// ### test/can_pin_ram_model.sv
// Purpose: Far side: CAN bus pins and message RAM
// Assumes: Same clock as the register group
// Notes: Stall input holds back RAM ready
`default_nettype none
module can_pin_ram_model
(
    input wire logic clk,
    input wire logic canTxPin,
    input wire logic ramSel,
    input wire logic stall,
    output logic canRxPin,
    output logic ramReady
);
    timeunit 1ns;
    timeprecision 1ps;
    // Single node bus: receive sees own transmit level
    assign canRxPin = canTxPin;
    // RAM answers one cycle after select unless stalled
    always_ff @(posedge clk)
        ramReady <= ramSel && !stall;
endmodule
`default_nettype wire

// ### test/test_can_core_id_timing_test_regs.sv
// Purpose: Self-checking bench for the low register group
// Assumes: APB slave answers in its own time
// Notes: Rows cover reset reads; hand tests follow
`default_nettype none
module test_can_core_id_timing_test_regs;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    localparam logic [31:0] M = 32'hFFFFFFFF;
    logic clk = 1'h0, rst_b = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic ramSel = 1'h0, stall = 1'h0, se, pready, pslverr, canRxPin, canTxPin;
    logic txDelayCompEn, txCtrlPin, ramReady, flag, loopbackActive, muxPin, coreRx, sp;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [4:0] dataSyncJumpWidth;
    logic [5:0] st = 6'h35, pr = 6'h2A; // Valid flag above index
    int errors = 0, num_checks = 0, cyc = 0, toCnt = 0, spCnt = 0, spBase = 0;
    // Address beside expected reset read
    logic [43:0] rows [5] = '{{12'h000, 32'h10000101}, {12'h004, 32'h87654321},
        {12'h008, 32'h0}, {12'h00C, 32'h00000A33}, {12'h014, 32'h0}};
    initial forever #4 clk = ~clk;
    can_core_id_timing_test_regs u_dut (.clk, .rst_b, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .canRxPin, .canTxPin, .coreTxNext(1'b1),
        .coreRx, .samplePoint(sp), .bitEnd(), .txDelayCompEn, .dataSyncJumpWidth,
        .startedIndexValid(st[5]), .startedTxBufferIndex(st[4:0]),
        .preparedIndexValid(pr[5]), .preparedTxBufferIndex(pr[4:0]), .scheduleTxCtrl(1'b0),
        .scheduleMuxCtrl(1'b0), .txCtrlPin, .muxCtrlPin(muxPin), .ramSel, .ramReady,
        .watchdogTimeoutFlag(flag), .loopbackActive);
    can_pin_ram_model u_far (.clk, .canTxPin, .ramSel, .stall, .canRxPin, .ramReady);
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e)
        begin
            errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // One APB transfer, held until pready, then an idle cycle
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Answer is looked at mid-cycle, while it stands
        do
        begin
            @(negedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        errors += int'(n >= 20);
        q = prdata;
        se = pslverr;
        @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
        apb(1'b0, a, 32'h0);
        chk(q & m, e);
    endtask
    task results;
        $display("errors=%0d checks=%0d", errors, num_checks);
        if (errors == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Hang guard and timeout pulse count
    always @(posedge clk)
    begin
        cyc++;
        toCnt += int'(flag === 1'b1);
        spCnt += int'(sp === 1'b1);
        if (cyc == 3000)
        begin
            errors++;
            results();
        end
    end
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial
    begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        foreach (rows[i])
            rd(rows[i][43:32], rows[i][31:0], M);
        rd(12'h100, 32'h0, M);
        chk({31'h0, se}, 32'h1);
        apb(1'b1, 12'h00C, 32'hFFE1FFFF);
        rd(12'h00C, 32'h00000A33, M);
        apb(1'b1, 12'h018, 32'h3);
        // Prescaler 1 with compensation on, rate kept high
        apb(1'b1, 12'h00C, 32'hFFE1FFFF);
        rd(12'h00C, 32'h00811FFF, M);
        chk({26'h0, txDelayCompEn, dataSyncJumpWidth}, 32'h30);
        // Leave init: 49 quanta of 2 clocks give one sample point per 98 clocks
        apb(1'b1, 12'h018, 32'h0);
        spBase = spCnt;
        repeat (196) @(posedge clk);
        chk(spCnt - spBase, 32'h2);
        apb(1'b1, 12'h010, 32'h53);
        rd(12'h010, 32'h00352A00, 32'hFFFFFF7F);
        apb(1'b1, 12'h018, 32'h83);
        apb(1'b1, 12'h010, 32'h53);
        // Receive level needs two more stages after the pin drops
        repeat (2) @(posedge clk);
        rd(12'h010, 32'h00352A5F, M);
        chk({27'h0, canTxPin, loopbackActive, txCtrlPin, muxPin, coreRx}, 32'hE);
        apb(1'b1, 12'h018, 32'h3);
        @(negedge clk);
        chk({31'h0, loopbackActive}, 32'h0);
        apb(1'b1, 12'h014, 32'h3);
        // Stalled RAM times out once; answering RAM does not
        for (int k = 1; k >= 0; k--)
        begin
            stall <= k[0];
            ramSel <= 1'b1;
            @(posedge clk);
            ramSel <= 1'b0;
            repeat (12) @(posedge clk);
            chk(toCnt, 32'h1);
            rd(12'h014, 32'h3, (k == 1) ? M : 32'hFF);
        end
        results();
    end
endmodule
`default_nettype wire
